// file: rtl/startup_seq_pkg.sv
// Purpose: Shared constants and types for the converter startup sequencer
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite register port
// Notes:   Offsets are byte addresses of aligned 32-bit words
package startup_seq_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] EVENT_OFS  = 8'h0C;

  // Control register fields
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_CAL_EN_BIT  = 1;
  localparam int CTRL_TRIG_BIT    = 2;
  localparam int CTRL_OVERRANGE_REPORT_ENABLE_BIT  = 3;

  // Configuration register fields
  localparam int CFG_LANE_FMT_LSB = 0;
  localparam int CFG_KM1_LSB      = 8;
  localparam int CFG_SYNC_SEL_BIT = 16;
  localparam int CFG_CAL_BG_BIT   = 17;
  localparam int CFG_OFS_CAL_BIT  = 18;

  // Status and event register fields
  localparam int STAT_LINK_LSB     = 0;
  localparam int STAT_CAL_BUSY_BIT = 2;
  localparam int STAT_OVR_BIT      = 3;
  localparam int EVT_REFUSED_BIT   = 0;
  localparam int EVT_CAL_DONE_BIT  = 1;

  // Values after reset
  localparam logic       CTRL_LINK_EN_RST = 1'b0;
  localparam logic       CTRL_CAL_EN_RST  = 1'b0;
  localparam logic [4:0] LANE_FMT_RST     = 5'h00;
  localparam logic [4:0] KM1_RST          = 5'h1F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Calibration phase durations
  localparam int CAL_GAIN_TIME_NS   = 20000;
  localparam int CAL_OFFSET_TIME_NS = 5000;
  localparam logic [11:0] CAL_GAIN_CYCLES =
    12'((CAL_GAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CAL_OFFSET_CYCLES =
    12'((CAL_OFFSET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Serial link states
  typedef enum logic [1:0] {
    LINK_HALT = 2'b00,
    LINK_CGS  = 2'b01,
    LINK_ILAS = 2'b10,
    LINK_DATA = 2'b11
  } link_state_e;

  // Calibration states
  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_GAIN   = 2'b01,
    CAL_OFFSET = 2'b10
  } cal_state_e;

endpackage

// file: rtl/pin_sync2.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s state_ff;
  sync_s nxt_state;

  // Shift through both stages
  always_comb begin
    nxt_state.meta   = async_in;
    nxt_state.stable = state_ff.meta;
  end

  // Idle-high reset suits active-low sync pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;

endmodule

// file: rtl/cal_engine.sv
// Purpose: Calibration state machine with gain and offset phases
// Assumes: Control levels come from registers on aclk
// Notes:   Background mode re-runs calibration while enabled
`timescale 1ns/10ps
module cal_engine (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic run_enable,
  input  wire logic soft_trigger,
  input  wire logic background_mode,
  input  wire logic offset_enable,
  // Status
  output logic      busy,
  output logic      done_pulse
);

  typedef struct packed {
    startup_seq_pkg::cal_state_e st;
    logic [11:0]                 cnt;
    logic                        trig_prev;
    logic                        busy;
    logic                        done;
  } cal_s;

  cal_s state_ff;
  cal_s nxt_state;
  logic trig_rise;

  // Start on a zero-to-one edge of the trigger
  assign trig_rise = soft_trigger && !state_ff.trig_prev;

  // Phase sequencing
  always_comb begin
    nxt_state           = state_ff;
    nxt_state.trig_prev = soft_trigger;
    nxt_state.done      = 1'b0;
    if (!run_enable) begin
      nxt_state.st  = startup_seq_pkg::CAL_IDLE;
      nxt_state.cnt = 12'h000;
    end else begin
      unique case (state_ff.st)
        startup_seq_pkg::CAL_IDLE: begin
          if (trig_rise || background_mode) begin
            nxt_state.st  = startup_seq_pkg::CAL_GAIN;
            nxt_state.cnt = startup_seq_pkg::CAL_GAIN_CYCLES - 12'h001;
          end
        end
        startup_seq_pkg::CAL_GAIN: begin
          if (state_ff.cnt != 12'h000) begin
            nxt_state.cnt = state_ff.cnt - 12'h001;
          end else if (offset_enable) begin
            nxt_state.st  = startup_seq_pkg::CAL_OFFSET;
            nxt_state.cnt = startup_seq_pkg::CAL_OFFSET_CYCLES - 12'h001;
          end else begin
            nxt_state.st   = startup_seq_pkg::CAL_IDLE;
            nxt_state.done = 1'b1;
          end
        end
        startup_seq_pkg::CAL_OFFSET: begin
          if (state_ff.cnt != 12'h000) begin
            nxt_state.cnt = state_ff.cnt - 12'h001;
          end else begin
            nxt_state.st   = startup_seq_pkg::CAL_IDLE;
            nxt_state.done = 1'b1;
          end
        end
        default: begin
          nxt_state.st = startup_seq_pkg::CAL_IDLE;
        end
      endcase
    end
    nxt_state.busy = (nxt_state.st != startup_seq_pkg::CAL_IDLE);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busy       = state_ff.busy;
  assign done_pulse = state_ff.done;

endmodule

// file: rtl/converter_startup_sequencer.sv
// Purpose: Register file, link and calibration control of the converter
// Assumes: AXI4-Lite master on aclk; sync pins asynchronous
// Notes:   Configuration is writable only while link and calibration halt
`timescale 1ns/10ps
module converter_startup_sequencer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sync pins, active low
  input  wire logic        single_ended_sync_input_n,
  input  wire logic        timestamp_sync_n,
  // Converter core
  input  wire logic        overrange_detect,
  // Link, calibration and over-range outputs
  output logic             link_data_valid,
  output logic [4:0]       lane_format_select,
  output logic [4:0]       multiframe_length_minus_one,
  output logic             overrange_flag,
  output logic             calibration_busy
);

  typedef struct packed {
    // Write channel
    logic                         awready;
    logic                         wready;
    logic                         aw_got;
    logic                         w_got;
    logic [7:0]                   awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    // Read channel
    logic                         arready;
    logic                         rvalid;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
    // Control and configuration
    logic                         serial_link_enable;
    logic                         cal_run_enable;
    logic                         calibration_software_trigger;
    logic                         overrange_report_enable;
    logic [4:0]                   lane_fmt;
    logic [4:0]                   km1;
    logic                         sync_sel;
    logic                         cal_bg;
    logic                         ofs_cal;
    // Events
    logic                         cfg_refused;
    logic                         cal_done;
    // Link, over-range and calibration status
    startup_seq_pkg::link_state_e link_st;
    logic [7:0]                   ilas_cnt;
    logic                         link_up;
    logic                         ovr_flag;
    logic                         cal_busy;
  } top_s;

  top_s        state_ff;
  top_s        nxt_state;
  logic [1:0]  sync_pins;
  logic        sync_n;
  logic        cal_busy_w;
  logic        cal_done_w;
  logic        wr_fire;
  logic        ar_fire;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Address decode shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == startup_seq_pkg::CTRL_OFS) || (addr == startup_seq_pkg::CONFIG_OFS) ||
           (addr == startup_seq_pkg::STATUS_OFS) || (addr == startup_seq_pkg::EVENT_OFS);
  endfunction

  // Pin synchronisers
  pin_sync2 #(
    .WIDTH (2)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({timestamp_sync_n, single_ended_sync_input_n}),
    .sync_out (sync_pins)
  );

  // Selected sync source
  assign sync_n = state_ff.sync_sel ? sync_pins[1] : sync_pins[0];

  // Calibration engine
  cal_engine u_cal (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .run_enable      (state_ff.cal_run_enable),
    .soft_trigger    (state_ff.calibration_software_trigger),
    .background_mode (state_ff.cal_bg),
    .offset_enable   (state_ff.ofs_cal),
    .busy            (cal_busy_w),
    .done_pulse      (cal_done_w)
  );

  assign wr_fire = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
  assign ar_fire = s_axi_arvalid && state_ff.arready;

  // Next-state logic
  always_comb begin
    logic [31:0] ctrl_v;
    logic [31:0] cfg_v;
    logic [31:0] wr_v;
    logic        halted;
    logic        clr_refused;
    logic        clr_done;
    logic        set_refused;
    ctrl_v      = '0;
    cfg_v       = '0;
    wr_v        = '0;
    clr_refused = 1'b0;
    clr_done    = 1'b0;
    set_refused = 1'b0;
    nxt_state   = state_ff;
    halted      = !state_ff.serial_link_enable && !state_ff.cal_run_enable;

    // Capture write address and data in either order
    if (s_axi_awvalid && state_ff.awready) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // Register write
    if (wr_fire) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = is_mapped(state_ff.awaddr) ? startup_seq_pkg::RESP_OKAY
                                                    : startup_seq_pkg::RESP_SLVERR;
      ctrl_v = '0;
      ctrl_v[startup_seq_pkg::CTRL_LINK_EN_BIT] = state_ff.serial_link_enable;
      ctrl_v[startup_seq_pkg::CTRL_CAL_EN_BIT]  = state_ff.cal_run_enable;
      ctrl_v[startup_seq_pkg::CTRL_TRIG_BIT]    = state_ff.calibration_software_trigger;
      ctrl_v[startup_seq_pkg::CTRL_OVERRANGE_REPORT_ENABLE_BIT]  = state_ff.overrange_report_enable;
      cfg_v  = '0;
      cfg_v[startup_seq_pkg::CFG_LANE_FMT_LSB +: 5] = state_ff.lane_fmt;
      cfg_v[startup_seq_pkg::CFG_KM1_LSB +: 5]      = state_ff.km1;
      cfg_v[startup_seq_pkg::CFG_SYNC_SEL_BIT]      = state_ff.sync_sel;
      cfg_v[startup_seq_pkg::CFG_CAL_BG_BIT]        = state_ff.cal_bg;
      cfg_v[startup_seq_pkg::CFG_OFS_CAL_BIT]       = state_ff.ofs_cal;
      if (state_ff.awaddr == startup_seq_pkg::CTRL_OFS) begin
        wr_v = merge_bytes(ctrl_v, state_ff.wdata, state_ff.wstrb);
        nxt_state.serial_link_enable           = wr_v[startup_seq_pkg::CTRL_LINK_EN_BIT];
        nxt_state.cal_run_enable               = wr_v[startup_seq_pkg::CTRL_CAL_EN_BIT];
        nxt_state.calibration_software_trigger = wr_v[startup_seq_pkg::CTRL_TRIG_BIT];
        nxt_state.overrange_report_enable      = wr_v[startup_seq_pkg::CTRL_OVERRANGE_REPORT_ENABLE_BIT];
      end else if (state_ff.awaddr == startup_seq_pkg::CONFIG_OFS) begin
        // Settings change only while both machines are halted
        if (halted) begin
          wr_v = merge_bytes(cfg_v, state_ff.wdata, state_ff.wstrb);
          nxt_state.lane_fmt = wr_v[startup_seq_pkg::CFG_LANE_FMT_LSB +: 5];
          nxt_state.km1      = wr_v[startup_seq_pkg::CFG_KM1_LSB +: 5];
          nxt_state.sync_sel = wr_v[startup_seq_pkg::CFG_SYNC_SEL_BIT];
          nxt_state.cal_bg   = wr_v[startup_seq_pkg::CFG_CAL_BG_BIT];
          nxt_state.ofs_cal  = wr_v[startup_seq_pkg::CFG_OFS_CAL_BIT];
        end else begin
          set_refused = 1'b1;
        end
      end else if (state_ff.awaddr == startup_seq_pkg::EVENT_OFS && state_ff.wstrb[0]) begin
        clr_refused = state_ff.wdata[startup_seq_pkg::EVT_REFUSED_BIT];
        clr_done    = state_ff.wdata[startup_seq_pkg::EVT_CAL_DONE_BIT];
      end
    end

    // Sticky events, set beats clear
    nxt_state.cfg_refused = set_refused || (state_ff.cfg_refused && !clr_refused);
    nxt_state.cal_done    = cal_done_w || (state_ff.cal_done && !clr_done);
    nxt_state.cal_busy    = cal_busy_w;

    // Channel readies
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready  = !nxt_state.w_got && !nxt_state.bvalid;

    // Register read
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (ar_fire) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = '0;
      nxt_state.rresp  = is_mapped(s_axi_araddr) ? startup_seq_pkg::RESP_OKAY
                                                 : startup_seq_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        startup_seq_pkg::CTRL_OFS: begin
          nxt_state.rdata[startup_seq_pkg::CTRL_LINK_EN_BIT] = state_ff.serial_link_enable;
          nxt_state.rdata[startup_seq_pkg::CTRL_CAL_EN_BIT]  = state_ff.cal_run_enable;
          nxt_state.rdata[startup_seq_pkg::CTRL_TRIG_BIT]    =
            state_ff.calibration_software_trigger;
          nxt_state.rdata[startup_seq_pkg::CTRL_OVERRANGE_REPORT_ENABLE_BIT]  = state_ff.overrange_report_enable;
        end
        startup_seq_pkg::CONFIG_OFS: begin
          nxt_state.rdata[startup_seq_pkg::CFG_LANE_FMT_LSB +: 5] = state_ff.lane_fmt;
          nxt_state.rdata[startup_seq_pkg::CFG_KM1_LSB +: 5]      = state_ff.km1;
          nxt_state.rdata[startup_seq_pkg::CFG_SYNC_SEL_BIT]      = state_ff.sync_sel;
          nxt_state.rdata[startup_seq_pkg::CFG_CAL_BG_BIT]        = state_ff.cal_bg;
          nxt_state.rdata[startup_seq_pkg::CFG_OFS_CAL_BIT]       = state_ff.ofs_cal;
        end
        startup_seq_pkg::STATUS_OFS: begin
          nxt_state.rdata[startup_seq_pkg::STAT_LINK_LSB +: 2] = state_ff.link_st;
          nxt_state.rdata[startup_seq_pkg::STAT_CAL_BUSY_BIT]  = state_ff.cal_busy;
          nxt_state.rdata[startup_seq_pkg::STAT_OVR_BIT]       = state_ff.ovr_flag;
        end
        startup_seq_pkg::EVENT_OFS: begin
          nxt_state.rdata[startup_seq_pkg::EVT_REFUSED_BIT]  = state_ff.cfg_refused;
          nxt_state.rdata[startup_seq_pkg::EVT_CAL_DONE_BIT] = state_ff.cal_done;
        end
        default: begin
          nxt_state.rdata = '0;
        end
      endcase
    end
    nxt_state.arready = !nxt_state.rvalid;

    // Serial link state machine
    if (!state_ff.serial_link_enable) begin
      nxt_state.link_st  = startup_seq_pkg::LINK_HALT;
      nxt_state.ilas_cnt = 8'h00;
    end else begin
      unique case (state_ff.link_st)
        startup_seq_pkg::LINK_HALT: begin
          nxt_state.link_st = startup_seq_pkg::LINK_CGS;
        end
        startup_seq_pkg::LINK_CGS: begin
          // Leave code group sync when receiver releases sync
          if (sync_n) begin
            nxt_state.link_st  = startup_seq_pkg::LINK_ILAS;
            nxt_state.ilas_cnt = {1'b0, state_ff.km1, 2'b11};
          end
        end
        startup_seq_pkg::LINK_ILAS: begin
          // Four multiframes of alignment, resync on request
          if (!sync_n) begin
            nxt_state.link_st = startup_seq_pkg::LINK_CGS;
          end else if (state_ff.ilas_cnt == 8'h00) begin
            nxt_state.link_st = startup_seq_pkg::LINK_DATA;
          end else begin
            nxt_state.ilas_cnt = state_ff.ilas_cnt - 8'h01;
          end
        end
        startup_seq_pkg::LINK_DATA: begin
          if (!sync_n) begin
            nxt_state.link_st = startup_seq_pkg::LINK_CGS;
          end
        end
      endcase
    end
    nxt_state.link_up  = (nxt_state.link_st == startup_seq_pkg::LINK_DATA);

    // Over-range reporting gate
    nxt_state.ovr_flag = state_ff.overrange_report_enable && overrange_detect;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff                    <= '0;
      state_ff.awready            <= 1'b1;
      state_ff.wready             <= 1'b1;
      state_ff.arready            <= 1'b1;
      state_ff.serial_link_enable <= startup_seq_pkg::CTRL_LINK_EN_RST;
      state_ff.cal_run_enable     <= startup_seq_pkg::CTRL_CAL_EN_RST;
      state_ff.lane_fmt           <= startup_seq_pkg::LANE_FMT_RST;
      state_ff.km1                <= startup_seq_pkg::KM1_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs from flops
  assign s_axi_awready               = state_ff.awready;
  assign s_axi_wready                = state_ff.wready;
  assign s_axi_bvalid                = state_ff.bvalid;
  assign s_axi_bresp                 = state_ff.bresp;
  assign s_axi_arready               = state_ff.arready;
  assign s_axi_rvalid                = state_ff.rvalid;
  assign s_axi_rresp                 = state_ff.rresp;
  assign s_axi_rdata                 = state_ff.rdata;
  assign link_data_valid             = state_ff.link_up;
  assign lane_format_select          = state_ff.lane_fmt;
  assign multiframe_length_minus_one = state_ff.km1;
  assign overrange_flag              = state_ff.ovr_flag;
  assign calibration_busy            = state_ff.cal_busy;

endmodule

// file: verification/startup_seq_chk.sv
// Purpose: Assertions on bus timing and control effects
// Assumes: Address and data of a write are offered together
// Notes:   ctl_ff mirrors the control word as it lands
`timescale 1ns/10ps
module startup_seq_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Core side
  input wire logic        overrange_detect,
  input wire logic        link_data_valid,
  input wire logic [4:0]  lane_format_select,
  input wire logic [4:0]  multiframe_length_minus_one,
  input wire logic        overrange_flag,
  input wire logic        calibration_busy
);
  logic       hs_ff, hit_ff;
  logic [3:0] wd_ff, ctl_ff;
  wire        hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Mirror the control word at the edge the write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_ff  <= 1'b0;
      ctl_ff <= 4'h0;
    end else begin
      hs_ff <= hs;
      if (hs) begin
        wd_ff  <= s_axi_wdata[3:0];
        hit_ff <= s_axi_awaddr == startup_seq_pkg::CTRL_OFS;
      end
      // Lands one edge after the handshake, as the register does
      if (hs_ff && hit_ff) ctl_ff <= wd_ff;
    end
  end

  // Control and bus relations
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LINK_HALT: assert property (!ctl_ff[0] |=> !link_data_valid)
    else $error("link active while disabled");
  AST_CAL_HALT: assert property (!ctl_ff[1] |-> ##2 !calibration_busy)
    else $error("calibration running while disabled");
  AST_CAL_START: assert property ($rose(ctl_ff[2]) && ctl_ff[1] |->
    ##[1:4] calibration_busy)
    else $error("trigger edge did not start calibration");
  AST_LINK_UP: assert property ($rose(link_data_valid) |-> ctl_ff[0])
    else $error("link came up while disabled");
  AST_CFG_LOCK: assert property (ctl_ff[0] || ctl_ff[1] |=>
    $stable(lane_format_select) && $stable(multiframe_length_minus_one))
    else $error("settings changed while running");
  AST_OVR: assert property (overrange_flag == $past(overrange_detect && ctl_ff[3]))
    else $error("overrange flag wrong");
  AST_B_LAT: assert property (hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  cover property ($rose(link_data_valid));
  cover property ($fell(calibration_busy));
  cover property (s_axi_bvalid && hs_ff);
endmodule

// file: verification/link_rx_model.sv
// Purpose: Link receiver model driving the sync request
// Assumes: Sync request is active low
// Notes:   Requests sync for HOLD cycles after reset or resync
`timescale 1ns/10ps
module link_rx_model #(
  parameter int HOLD = 20
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control and pin
  input  wire logic resync,
  output logic      sync_n
);
  int cnt;
  // Count down the sync request
  always_ff @(posedge aclk) begin
    if (!aresetn || resync) cnt <= HOLD;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign sync_n = (cnt == 0);
endmodule

// file: verification/converter_startup_sequencer_tb.sv
// Purpose: Bench for the converter startup sequencer
// Assumes: Bus tasks offer address and data together
// Notes:   Host steps follow the startup order
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module converter_startup_sequencer_tb;
  logic        aclk = 0, aresetn = 0, aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0;
  logic        r_rdy = 0, ovr_det = 0, resync = 0, ts_n = 1, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic        ldv, ovf, cbusy, sync_n;
  logic [7:0]  aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_d, v;
  logic [4:0]  lfs, km1;
  logic [1:0]  b_resp, r_resp, resp;
  int          mismatches = 0, n_checks = 0;

  always #5 aclk = ~aclk;

  converter_startup_sequencer i_converter_startup_sequencer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .single_ended_sync_input_n(sync_n), .timestamp_sync_n(ts_n),
    .overrange_detect(ovr_det), .link_data_valid(ldv), .lane_format_select(lfs),
    .multiframe_length_minus_one(km1), .overrange_flag(ovf), .calibration_busy(cbusy));
  link_rx_model i_link_rx_model (.aclk(aclk), .aresetn(aresetn), .resync(resync),
    .sync_n(sync_n));

  // Verdict and end of run
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A wait that ran out ends the run
  task automatic to(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  // Bus write, held until each channel is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw_a  <= a;
    w_d   <= d;
    aw_v  <= 1'b1;
    w_v   <= 1'b1;
    b_rdy <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
      if (b_v) break;
    end
    to(b_v);
    resp = b_resp;
    b_rdy <= 1'b0;
    // Let an edge pass before the next call raises it again
    @(posedge aclk);
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a);
    ar_a  <= a;
    ar_v  <= 1'b1;
    r_rdy <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (ar_rdy) ar_v <= 1'b0;
      if (r_v) break;
    end
    to(r_v);
    v = r_d;
    resp = r_resp;
    r_rdy <= 1'b0;
    @(posedge aclk);
  endtask

  // Startup sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h04);
    `CHK(v, 32'h00001F00)
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00040103);
    `CHK({lfs, km1}, 10'h061)
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h0);
    rd(8'h04);
    `CHK(v, 32'h00040103)
    rd(8'h0C);
    `CHK(v[0], 1'b1)
    ovr_det <= 1'b1;
    wr(8'h00, 32'hA);
    @(posedge aclk);
    `CHK(ovf, 1'b1)
    wr(8'h00, 32'hB);
    for (int i = 0; i < 300 && !ldv; i++) @(posedge aclk);
    to(ldv);
    rd(8'h08);
    `CHK(v[1:0], 2'h3)
    resync <= 1'b1;
    @(posedge aclk);
    resync <= 1'b0;
    for (int i = 0; i < 10 && ldv; i++) @(posedge aclk);
    `CHK(ldv, 1'b0)
    wr(8'h00, 32'hF);
    for (int i = 0; i < 20 && !cbusy; i++) @(posedge aclk);
    to(cbusy);
    for (int i = 0; i < 3000 && cbusy; i++) @(posedge aclk);
    to(!cbusy);
    rd(8'h0C);
    `CHK(v[1], 1'b1)
    wr(8'h0C, 32'h3);
    `CHK(resp, startup_seq_pkg::RESP_OKAY)
    rd(8'h0C);
    `CHK(v[1:0], 2'h0)
    wr(8'h00, 32'h0);
    @(posedge aclk);
    `CHK(ldv, 1'b0)
    wr(8'h04, 32'h00050103);
    ts_n <= 1'b0;
    wr(8'h00, 32'h1);
    rd(8'h08);
    `CHK(v[1:0], 2'h1)
    ts_n <= 1'b1;
    for (int i = 0; i < 50 && !ldv; i++) @(posedge aclk);
    to(ldv);
    rd(8'h10);
    `CHK({resp, v}, {startup_seq_pkg::RESP_SLVERR, 32'h0})
    end_sim();
  end
endmodule
bind converter_startup_sequencer startup_seq_chk i_startup_seq_chk (.*);
